// ### src/wkg_top.sv
// Wake enable gating: enable registers, wake status, summary flag and event output.
`timescale 1ns/10ps
`include "wkg_map.svh"
module wkg_top
	import wkg_pkg::*;
(
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic standbyPowerOnReset,
	// Avalon-MM slave
	input wire wkg_addr_t avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// Wake source pins
	input wire logic [7:0] gpioPins1x,
	input wire logic [4:0] gpioPins2x,
	input wire logic [7:0] gpioPins3x,
	input wire logic ringIndicatePortOne,
	input wire logic ringIndicatePortTwo,
	// Event and interrupt outputs
	output logic powerEventOutN,
	output logic irqOut
);
	wkg_bus_st_t busState_reg;
	wkg_bus_st_t busState_next;
	wkg_idx_t regIdx;
	wkg_byte_t wrByte;
	logic wrAccept;
	logic rdFirst;
	logic [31:0] readNext;
	logic [31:0] readdata_reg;
	wkg_byte_t wakeEnableGroupA_reg;
	wkg_byte_t wakeEnableGroupB_reg;
	wkg_byte_t wakeEnableGroupC_reg;
	logic globalWakeEnable_reg;
	logic wakeSummaryFlag_reg;
	logic [23:0] matchVec;
	logic [23:0] matchPrev_reg;
	logic newMatch;
	logic pending;
	logic summaryClear;
	logic powerEventOutN_reg;
	wkg_irq_t irqStatus_reg;
	wkg_irq_t irqEnable_reg;
	wkg_irq_t irqEvents;
	wkg_irq_t irqClear;
	logic irqOut_reg;
	wkg_byte_t pinsB;

	wkg_grp_if #(.W(8)) grpA ();
	wkg_grp_if #(.W(8)) grpB ();
	wkg_grp_if #(.W(8)) grpC ();

	// True when an accepted write with lane 0 targets the given index.
	function automatic logic wrHit(input logic acc, input wkg_idx_t idx, input wkg_idx_t want);
		return acc && (idx == want);
	endfunction

	// Byte of write data that lands on a register when it is selected.
	function automatic wkg_byte_t wrMasked(input logic hit, input wkg_byte_t data);
		return hit ? data : `WKG_ZERO8;
	endfunction

	// Group B carries the ring indicates in its low bits, pins 20-24 above.
	assign pinsB = {1'b0, gpioPins2x, ringIndicatePortTwo, ringIndicatePortOne};

	// Capture for pins 10 to 17.
	wkg_event_capture #(.W(8), .LIVE_MASK(`WKG_MASK_FULL)) captureA (
		.clk(clk),
		.rst(rst),
		.standbyPowerOnReset(standbyPowerOnReset),
		.pinsIn(gpioPins1x),
		.grp(grpA)
	);

	// Capture for ring indicates and pins 20 to 24; bit 7 never sets.
	wkg_event_capture #(.W(8), .LIVE_MASK(`WKG_MASK_B)) captureB (
		.clk(clk),
		.rst(rst),
		.standbyPowerOnReset(standbyPowerOnReset),
		.pinsIn(pinsB),
		.grp(grpB)
	);

	// Capture for pins 30 to 37.
	wkg_event_capture #(.W(8), .LIVE_MASK(`WKG_MASK_FULL)) captureC (
		.clk(clk),
		.rst(rst),
		.standbyPowerOnReset(standbyPowerOnReset),
		.pinsIn(gpioPins3x),
		.grp(grpC)
	);

	// Word index and write byte of the current request.
	assign regIdx = avsAddress[`WKG_IDX_MSB:`WKG_IDX_LSB];
	assign wrByte = avsWritedata[7:0];

	// Every request waits one cycle, then is answered.
	always_comb begin
		busState_next = busState_reg;
		case (busState_reg)
			WKG_BUS_IDLE: begin
				if (avsRead || avsWrite) begin
					busState_next = WKG_BUS_ACK;
				end
			end
			WKG_BUS_ACK: begin
				busState_next = WKG_BUS_IDLE;
			end
			default: begin
				busState_next = WKG_BUS_IDLE;
			end
		endcase
	end

	// Bus phase register.
	always_ff @(posedge clk) begin
		if (rst) begin
			busState_reg <= WKG_BUS_IDLE;
		end else begin
			busState_reg <= busState_next;
		end
	end

	// Waitrequest drops in the second cycle of a request.
	assign avsWaitrequest = (avsRead || avsWrite) && (busState_reg != WKG_BUS_ACK);
	assign wrAccept = avsWrite && (busState_reg == WKG_BUS_ACK) && avsByteenable[0];
	assign rdFirst = avsRead && (busState_reg == WKG_BUS_IDLE);

	// Read multiplexer; unmapped and write-only words read as zero.
	always_comb begin
		readNext = `WKG_ZERO32;
		case (regIdx)
			`WKG_IDX_SUMMARY: readNext[`WKG_SUM_BIT] = wakeSummaryFlag_reg;
			`WKG_IDX_GLOBAL: readNext[`WKG_GEN_BIT] = globalWakeEnable_reg;
			`WKG_IDX_STAT_A: readNext[7:0] = grpA.status;
			`WKG_IDX_STAT_B: readNext[7:0] = grpB.status;
			`WKG_IDX_STAT_C: readNext[7:0] = grpC.status;
			`WKG_IDX_EN_A: readNext[7:0] = wakeEnableGroupA_reg;
			`WKG_IDX_EN_B: readNext[7:0] = wakeEnableGroupB_reg;
			`WKG_IDX_EN_C: readNext[7:0] = wakeEnableGroupC_reg;
			`WKG_IDX_IRQ_STAT: readNext[1:0] = irqStatus_reg;
			`WKG_IDX_IRQ_EN: readNext[1:0] = irqEnable_reg;
			default: readNext = `WKG_ZERO32;
		endcase
	end

	// Read data are sampled in the first cycle and stand through the answer.
	always_ff @(posedge clk) begin
		if (rst) begin
			readdata_reg <= `WKG_ZERO32;
		end else if (rdFirst) begin
			readdata_reg <= readNext;
		end
	end

	assign avsReaddata = readdata_reg;

	// Enable registers answer only to the standby supply reset.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			wakeEnableGroupA_reg <= `WKG_ZERO8;
			wakeEnableGroupB_reg <= `WKG_ZERO8;
			wakeEnableGroupC_reg <= `WKG_ZERO8;
		end else begin
			if (wrHit(wrAccept, regIdx, `WKG_IDX_EN_A)) begin
				wakeEnableGroupA_reg <= wrByte;
			end
			if (wrHit(wrAccept, regIdx, `WKG_IDX_EN_B)) begin
				wakeEnableGroupB_reg <= wrByte & `WKG_MASK_B;
			end
			if (wrHit(wrAccept, regIdx, `WKG_IDX_EN_C)) begin
				wakeEnableGroupC_reg <= wrByte;
			end
		end
	end

	// Global enable, default off, kept across main resets.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			globalWakeEnable_reg <= 1'b0;
		end else if (wrHit(wrAccept, regIdx, `WKG_IDX_GLOBAL)) begin
			globalWakeEnable_reg <= wrByte[`WKG_GEN_BIT];
		end
	end

	// Writing ones to a wake status word clears those bits.
	assign grpA.clearBits = wrMasked(wrHit(wrAccept, regIdx, `WKG_IDX_STAT_A), wrByte);
	assign grpB.clearBits = wrMasked(wrHit(wrAccept, regIdx, `WKG_IDX_STAT_B), wrByte);
	assign grpC.clearBits = wrMasked(wrHit(wrAccept, regIdx, `WKG_IDX_STAT_C), wrByte);

	// Sources whose status and enable are both set.
	assign matchVec = {grpC.status & wakeEnableGroupC_reg,
		grpB.status & wakeEnableGroupB_reg,
		grpA.status & wakeEnableGroupA_reg};
	assign pending = |matchVec;
	assign newMatch = |(matchVec & ~matchPrev_reg);
	assign summaryClear = wrHit(wrAccept, regIdx, `WKG_IDX_SUMMARY) && wrByte[`WKG_SUM_BIT];

	// Previous match vector, used to find newly matched sources.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			matchPrev_reg <= `WKG_ZERO24;
		end else begin
			matchPrev_reg <= matchVec;
		end
	end

	// Summary flag sets on a new match whatever the global enable; a new match beats a clear.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			wakeSummaryFlag_reg <= 1'b0;
		end else begin
			wakeSummaryFlag_reg <= (wakeSummaryFlag_reg && !summaryClear) || newMatch;
		end
	end

	// Event output is low while enabled, flagged and matched.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			powerEventOutN_reg <= `WKG_OUT_IDLE;
		end else begin
			powerEventOutN_reg <= !(globalWakeEnable_reg && wakeSummaryFlag_reg && pending);
		end
	end

	assign powerEventOutN = powerEventOutN_reg;

	// Interrupt events: any source event, and a newly matched source.
	assign irqEvents[`WKG_IRQ_SRC_BIT] = (grpA.rise != `WKG_ZERO8) || (grpB.rise != `WKG_ZERO8)
		|| (grpC.rise != `WKG_ZERO8);
	assign irqEvents[`WKG_IRQ_PWR_BIT] = newMatch;
	assign irqClear = wrHit(wrAccept, regIdx, `WKG_IDX_IRQ_CLR) ? wrByte[1:0] : `WKG_ZERO2;

	// Sticky interrupt status and its enable; an event beats a clear.
	always_ff @(posedge clk) begin
		if (rst || standbyPowerOnReset) begin
			irqStatus_reg <= `WKG_ZERO2;
			irqEnable_reg <= `WKG_ZERO2;
		end else begin
			irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
			if (wrHit(wrAccept, regIdx, `WKG_IDX_IRQ_EN)) begin
				irqEnable_reg <= wrByte[1:0];
			end
		end
	end

	// Interrupt level follows enabled status one cycle later.
	always_ff @(posedge clk) begin
		if (rst || standbyPowerOnReset) begin
			irqOut_reg <= 1'b0;
		end else begin
			irqOut_reg <= |(irqStatus_reg & irqEnable_reg);
		end
	end

	assign irqOut = irqOut_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || standbyPowerOnReset);

	// Read of a word started in idle and answered in the next cycle.
	sequence rdAnswer(wkg_idx_t idx);
		rdFirst && (regIdx == idx) ##1 (avsRead && !avsWaitrequest);
	endsequence

	// Accepted write of one to the summary flag with no new match behind it.
	sequence sumCleared;
		summaryClear && !newMatch ##1 !newMatch;
	endsequence

	// The output is low only when all three conditions held before.
	out_low_cause_a: assert property (!powerEventOutN |-> $past(globalWakeEnable_reg)
		&& $past(wakeSummaryFlag_reg) && $past(pending))
		else $error("Event output low without a cause.");

	// Status on disabled sources alone never drives the output.
	disabled_no_drive_a: assert property ((matchVec == `WKG_ZERO24) |=> powerEventOutN)
		else $error("Disabled source drove the event output.");

	// Group A enable reads back at its index.
	read_enable_a_a: assert property (rdAnswer(`WKG_IDX_EN_A) |->
		(avsReaddata[7:0] == $past(wakeEnableGroupA_reg)))
		else $error("Group A enable read mismatch.");

	// Reserved bit of group B enable stays zero.
	reserved_b_zero_a: assert property (!wakeEnableGroupB_reg[7])
		else $error("Reserved enable bit set.");

	// Group C enable reads back at its index.
	read_enable_c_a: assert property (rdAnswer(`WKG_IDX_EN_C) |->
		(avsReaddata[7:0] == $past(wakeEnableGroupC_reg)))
		else $error("Group C enable read mismatch.");

	// Main reset leaves enables untouched.
	enable_keep_a: assert property (@(posedge clk) disable iff (standbyPowerOnReset)
		rst |=> $stable(wakeEnableGroupA_reg) && $stable(wakeEnableGroupB_reg)
		&& $stable(wakeEnableGroupC_reg) && $stable(globalWakeEnable_reg))
		else $error("Main reset changed an enable.");

	// Standby power-on clears all enables.
	standby_clear_a: assert property (@(posedge clk) standbyPowerOnReset |=>
		(wakeEnableGroupA_reg == `WKG_ZERO8) && (wakeEnableGroupB_reg == `WKG_ZERO8)
		&& (wakeEnableGroupC_reg == `WKG_ZERO8) && !globalWakeEnable_reg)
		else $error("Standby reset left an enable set.");

	// Global enable off keeps the output high.
	global_off_a: assert property (!globalWakeEnable_reg |=> powerEventOutN)
		else $error("Output asserted with global enable off.");

	// Clearing the summary flag releases the output.
	summary_clear_a: assert property (sumCleared |-> !wakeSummaryFlag_reg ##1 powerEventOutN)
		else $error("Summary clear did not release the output.");

	// Enabled, flagged and matched drives the output low next cycle.
	out_drive_a: assert property ((globalWakeEnable_reg && wakeSummaryFlag_reg && pending)
		|=> !powerEventOutN)
		else $error("Event output not driven low.");

	// Every request is answered within one cycle.
	bus_answer_a: assert property ((avsRead || avsWrite) |-> ##[0:1] !avsWaitrequest)
		else $error("Bus request not answered.");
endmodule

// ### src/wkg_map.svh
// Register indices, field positions, reset values and masks of the wake gating block.
`ifndef WKG_MAP_SVH
`define WKG_MAP_SVH
`define WKG_IDX_SUMMARY 5'h00
`define WKG_IDX_GLOBAL 5'h01
`define WKG_IDX_STAT_A 5'h02
`define WKG_IDX_STAT_B 5'h03
`define WKG_IDX_STAT_C 5'h04
`define WKG_IDX_EN_A 5'h05
`define WKG_IDX_EN_B 5'h06
`define WKG_IDX_EN_C 5'h07
`define WKG_IDX_IRQ_STAT 5'h10
`define WKG_IDX_IRQ_EN 5'h11
`define WKG_IDX_IRQ_CLR 5'h12
`define WKG_SUM_BIT 0
`define WKG_GEN_BIT 0
`define WKG_IRQ_SRC_BIT 0
`define WKG_IRQ_PWR_BIT 1
`define WKG_ZERO8 8'h00
`define WKG_ZERO2 2'h0
`define WKG_ZERO24 24'h000000
`define WKG_ZERO32 32'h00000000
`define WKG_MASK_B 8'h7F
`define WKG_MASK_FULL 8'hFF
`define WKG_OUT_IDLE 1'b1
`define WKG_IDX_MSB 6
`define WKG_IDX_LSB 2
`endif

// ### src/wkg_pkg.sv
// Types shared by the wake gating block.
package wkg_pkg;
	typedef logic [7:0] wkg_byte_t;
	typedef logic [4:0] wkg_idx_t;
	typedef logic [6:0] wkg_addr_t;
	typedef logic [1:0] wkg_irq_t;
	typedef enum logic [0:0] {
		WKG_BUS_IDLE = 1'b0,
		WKG_BUS_ACK = 1'b1
	} wkg_bus_st_t;
endpackage

// ### src/wkg_grp_if.sv
// Link between one wake source group capture and the register file.
`timescale 1ns/10ps
interface wkg_grp_if #(parameter int W = 8);
	logic [W-1:0] status;
	logic [W-1:0] clearBits;
	logic [W-1:0] rise;
	modport capture (output status, output rise, input clearBits);
	modport regs (input status, input rise, output clearBits);
endinterface

// ### src/wkg_event_capture.sv
// Synchroniser, edge detector and sticky wake status for one group of sources.
`timescale 1ns/10ps
`include "wkg_map.svh"
module wkg_event_capture
	import wkg_pkg::*;
#(
	parameter int W = 8,
	parameter logic [W-1:0] LIVE_MASK = '1
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic standbyPowerOnReset,
	// Wake pins of this group
	input wire logic [W-1:0] pinsIn,
	// Register side
	wkg_grp_if.capture grp
);
	logic [W-1:0] sync1_reg;
	logic [W-1:0] sync2_reg;
	logic [W-1:0] sync3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	// Three flip-flops bring the pins into the clock domain.
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= pinsIn;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A level changes only once the second and third stage agree.
	assign level_next = (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));

	// Filtered level; a pin already high at reset release counts as one event.
	always_ff @(posedge clk) begin
		if (rst) begin
			level_reg <= '0;
		end else begin
			level_reg <= level_next;
		end
	end

	// A wake event is a rising filtered level on a live bit.
	assign grp.rise = level_next & ~level_reg & LIVE_MASK;

	// Sticky status ignores the enables; a new event beats a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (standbyPowerOnReset) begin
			grp.status <= '0;
		end else begin
			grp.status <= ((grp.status & ~grp.clearBits) | grp.rise) & LIVE_MASK;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || standbyPowerOnReset);

	// Every event is recorded in status whatever the enables say.
	event_recorded_a: assert property ((grp.rise != '0) |=> ((grp.status & $past(grp.rise)) == $past(grp.rise)))
		else $error("Wake event not recorded in status.");

	// Status without a clear never loses a bit.
	status_sticky_a: assert property ((grp.clearBits == '0) |=> ((grp.status & $past(grp.status)) == $past(grp.status)))
		else $error("Wake status bit lost without a clear.");
endmodule

// ### verification/wkg_pm_partner.sv
// Model of the system power-management logic that watches the wake event output.
`timescale 1ns/10ps
module wkg_pm_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched event line
	input wire logic powerEventOutN,
	// Count of wake requests seen
	output logic [7:0] wakeCount
);
	logic prevLevel;

	// Counts each falling edge of the active-low event line as one wake request.
	always_ff @(posedge clk) begin
		if (rst) begin
			prevLevel <= 1'b1;
			wakeCount <= 8'h00;
		end else begin
			prevLevel <= powerEventOutN;
			if (prevLevel && !powerEventOutN) begin
				wakeCount <= wakeCount + 8'h01;
			end
		end
	end
endmodule

// ### verification/wkg_top_tb_top.sv
// Self-checking testbench of the wake gating block.
`timescale 1ns/10ps
module wkg_top_tb_top
	import wkg_pkg::*;
;
	logic clk, rst, standbyPowerOnReset, partnerRst;
	wkg_addr_t avsAddress;
	logic avsRead, avsWrite, avsWaitrequest, powerEventOutN, irqOut;
	logic [31:0] avsWritedata, avsReaddata;
	logic [3:0] avsByteenable;
	logic [7:0] gpioPins1x, gpioPins3x, wakeCount;
	logic [4:0] gpioPins2x;
	logic ringIndicatePortOne, ringIndicatePortTwo;
	int failures, checks;

	wkg_top dut_u (.clk(clk), .rst(rst), .standbyPowerOnReset(standbyPowerOnReset),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.gpioPins1x(gpioPins1x), .gpioPins2x(gpioPins2x), .gpioPins3x(gpioPins3x),
		.ringIndicatePortOne(ringIndicatePortOne), .ringIndicatePortTwo(ringIndicatePortTwo),
		.powerEventOutN(powerEventOutN), .irqOut(irqOut));

	wkg_pm_partner partner_u (.clk(clk), .rst(partnerRst), .powerEventOutN(powerEventOutN),
		.wakeCount(wakeCount));

	// Clock of 5 ns period.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checks++;
		if (seen !== expected) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	// One Avalon transfer; the request is held until waitrequest is seen low at a rising edge.
	task automatic bus_xfer(input logic wr, input wkg_idx_t idx, input wkg_byte_t wd,
		output wkg_byte_t rd);
		@(posedge clk);
		avsAddress <= {idx, 2'b00};
		avsRead <= !wr;
		avsWrite <= wr;
		avsWritedata <= {24'h000000, wd};
		do begin
			@(posedge clk);
		end while (avsWaitrequest !== 1'b0);
		rd = avsReaddata[7:0];
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	// Register write.
	task automatic wr(input wkg_idx_t idx, input wkg_byte_t wd);
		wkg_byte_t dummy;
		bus_xfer(1'b1, idx, wd, dummy);
	endtask

	// Register read compared with an expected byte.
	task automatic rd_chk(input wkg_idx_t idx, input wkg_byte_t expected);
		wkg_byte_t got;
		bus_xfer(1'b0, idx, 8'h00, got);
		check({24'h000000, got}, {24'h000000, expected});
	endtask

	// Waits some cycles and stops mid-cycle so outputs are settled.
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Raises the chosen wake pins for five cycles, then lets the status settle.
	// Group B is given as {pins 20-24, ring indicate two, ring indicate one}.
	task automatic pulse(input logic [7:0] a, input logic [7:0] c, input logic [6:0] b);
		@(posedge clk);
		gpioPins1x <= a;
		gpioPins3x <= c;
		ringIndicatePortOne <= b[0];
		ringIndicatePortTwo <= b[1];
		gpioPins2x <= b[6:2];
		repeat (5) @(posedge clk);
		gpioPins1x <= 8'h00;
		gpioPins3x <= 8'h00;
		ringIndicatePortOne <= 1'b0;
		ringIndicatePortTwo <= 1'b0;
		gpioPins2x <= 5'h00;
		idle(8);
	endtask

	// Output level checks, taken mid-cycle so that the outputs are settled.
	task automatic out_chk(input logic evtN, input logic irq);
		@(negedge clk);
		check({30'h0, powerEventOutN, irqOut}, {30'h0, evtN, irq});
	endtask

	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report();
	end

	// Main sequence.
	initial begin
		failures = 0;
		checks = 0;
		rst = 1'b1;
		standbyPowerOnReset = 1'b1;
		partnerRst = 1'b1;
		avsAddress = 7'h00;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWritedata = 32'h00000000;
		avsByteenable = 4'hF;
		gpioPins1x = 8'h00;
		gpioPins2x = 5'h00;
		gpioPins3x = 8'h00;
		ringIndicatePortOne = 1'b0;
		ringIndicatePortTwo = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		standbyPowerOnReset <= 1'b0;
		partnerRst <= 1'b0;
		// Standby power-on values.
		rd_chk(5'h05, 8'h00);
		rd_chk(5'h06, 8'h00);
		rd_chk(5'h07, 8'h00);
		rd_chk(5'h01, 8'h00);
		out_chk(1'b1, 1'b0);
		// Enable register layout, reserved bit and an unmapped index.
		wr(5'h05, 8'hFE);
		wr(5'h06, 8'hFF);
		wr(5'h07, 8'hA5);
		rd_chk(5'h05, 8'hFE);
		rd_chk(5'h06, 8'h7F);
		rd_chk(5'h07, 8'hA5);
		rd_chk(5'h1F, 8'h00);
		// A write without lane 0 is accepted but changes nothing.
		avsByteenable <= 4'hE;
		wr(5'h05, 8'h00);
		avsByteenable <= 4'hF;
		rd_chk(5'h05, 8'hFE);
		// Main reset leaves the enables alone.
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(5'h05, 8'hFE);
		rd_chk(5'h06, 8'h7F);
		rd_chk(5'h07, 8'hA5);
		// Disabled source is recorded but never drives the output.
		wr(5'h01, 8'h01);
		wr(5'h11, 8'h03);
		pulse(8'h01, 8'h00, 7'h00);
		rd_chk(5'h02, 8'h01);
		out_chk(1'b1, 1'b1);
		rd_chk(5'h00, 8'h00);
		rd_chk(5'h10, 8'h01);
		wr(5'h12, 8'h03);
		idle(2);
		out_chk(1'b1, 1'b0);
		wr(5'h02, 8'h01);
		rd_chk(5'h02, 8'h00);
		// Enabled source with the global enable off, interrupt masked.
		wr(5'h01, 8'h00);
		wr(5'h11, 8'h00);
		pulse(8'h02, 8'h00, 7'h00);
		rd_chk(5'h02, 8'h02);
		out_chk(1'b1, 1'b0);
		rd_chk(5'h00, 8'h01);
		rd_chk(5'h10, 8'h03);
		wr(5'h01, 8'h01);
		idle(3);
		out_chk(1'b0, 1'b0);
		check({24'h0, wakeCount}, 32'h00000001);
		// Summary flag: zero has no effect, one releases the output.
		wr(5'h00, 8'h00);
		idle(3);
		out_chk(1'b0, 1'b0);
		wr(5'h00, 8'h01);
		idle(3);
		out_chk(1'b1, 1'b0);
		rd_chk(5'h00, 8'h00);
		// Enabled sources in groups B and C at once; removing the group B enable keeps group C driving.
		wr(5'h02, 8'h02);
		pulse(8'h00, 8'h01, 7'h57);
		rd_chk(5'h03, 8'h57);
		rd_chk(5'h04, 8'h01);
		out_chk(1'b0, 1'b0);
		wr(5'h06, 8'h00);
		idle(3);
		out_chk(1'b0, 1'b0);
		wr(5'h07, 8'h00);
		idle(3);
		out_chk(1'b1, 1'b0);
		check({24'h0, wakeCount}, 32'h00000002);
		// Standby power-on in mid-run clears the group A and global enables and the group B status.
		wr(5'h05, 8'hFF);
		@(posedge clk);
		standbyPowerOnReset <= 1'b1;
		repeat (2) @(posedge clk);
		standbyPowerOnReset <= 1'b0;
		rd_chk(5'h05, 8'h00);
		rd_chk(5'h01, 8'h00);
		rd_chk(5'h03, 8'h00);
		out_chk(1'b1, 1'b0);
		final_report();
	end
endmodule
